// ---- include/nfc_regs.vh ----
// register map, field positions, reset values and timing counts of the flash host controller
`ifndef NFC_REGS_VH
`define NFC_REGS_VH
`define NFC_OFF_CTRL     8'h00
`define NFC_OFF_WPCTL    8'h04
`define NFC_OFF_CMD      8'h08
`define NFC_OFF_ADDR     8'h0c
`define NFC_OFF_COUNT    8'h10
`define NFC_OFF_BUFPTR   8'h14
`define NFC_OFF_BUFDATA  8'h18
`define NFC_OFF_STATUS   8'h1c
// operation codes in ctrl[2:0]
`define NFC_OP_CMD       3'h1
`define NFC_OP_ADDR      3'h2
`define NFC_OP_WDATA     3'h3
`define NFC_OP_RDATA     3'h4
`define NFC_OP_WAITRDY   3'h5
`define NFC_OP_DESEL     3'h6
// status bit positions
`define NFC_ST_BUSY      0
`define NFC_ST_RDY       1
`define NFC_ST_REFUSED   2
`define NFC_ST_DONE      3
`define NFC_ST_RBYTE_LO  8
// reset values
`define NFC_RST_WP_N     1'b0
`define NFC_RST_CMD      8'h00
// command codes
`define NFC_CMD_READ0    8'h00
`define NFC_CMD_PROG     8'h10
`define NFC_CMD_PROG_DUM 8'h11
`define NFC_CMD_PROG_MB  8'h15
`define NFC_CMD_ERASE2   8'hd0
`define NFC_CMD_STAT1    8'h70
`define NFC_CMD_STAT2    8'h71
`define NFC_CMD_RESET    8'hff
// geometry
`define NFC_PAGE_BYTES   528
`define NFC_MAX_PROGS    2'd3
// timing: figures in ns, counts at a 100 ns clock
`define NFC_CLK_NS       100
`define NFC_WP_NS        25
`define NFC_REA_NS       35
`define NFC_CEH_NS       100
`define NFC_WP_CYC       ((`NFC_WP_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS)
`define NFC_REA_CYC      ((`NFC_REA_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS)
`define NFC_CEH_CYC      ((`NFC_CEH_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS)
`define NFC_SYNC_CYC     2
`endif

// ---- hw/nfc_buf_mem.v ----
// page buffer of 528 bytes with a registered read port
module nfc_buf_mem (
  input  wire       pclk,   // clock
  input  wire       we,     // write strobe
  input  wire [9:0] waddr,  // write address
  input  wire [7:0] wdata,  // write data
  input  wire [9:0] raddr,  // read address
  output reg  [7:0] rdata   // read data, one cycle after raddr
);
  reg [7:0] mem [0:527];

  // no reset on the array; read data comes from a flop
  always @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// ---- hw/nfc_cycle.v ----
// one latch or strobe cycle on the flash pins: command, address, data write or byte read
`include "nfc_regs.vh"
module nfc_cycle (
  input  wire       pclk,      // clock
  input  wire       presetn,   // async reset, active low
  input  wire       start,     // one-cycle start pulse
  input  wire [1:0] kind,      // 0 command, 1 address, 2 data write, 3 read
  input  wire [7:0] wbyte,     // byte to put on the port
  output reg        done,      // one-cycle pulse at the end
  output reg  [7:0] rbyte_r,   // byte taken by the last read
  output reg        cle,       // command latch enable
  output reg        ale,       // address latch enable
  output reg        we_n,      // write strobe
  output reg        re_n,      // read strobe
  output reg  [7:0] io_out,    // port drive value
  output reg        io_oe,     // port drive enable
  input  wire [7:0] io_in      // port as seen on the pins
);
  localparam S_IDLE = 2'd0;
  localparam S_STRB = 2'd1;
  localparam S_HOLD = 2'd2;
  // strobe counts, cut to the counter width on purpose
  localparam integer WP_CYC = `NFC_WP_CYC;
  localparam integer RD_CYC = `NFC_REA_CYC + `NFC_SYNC_CYC;

  reg [1:0] state_r;
  reg [2:0] cnt_r;
  reg       rd_r;
  reg [7:0] io_s1_r;
  reg [7:0] io_s2_r;

  // port sampled through two flops before it is used
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_s1_r <= 8'h00;
      io_s2_r <= 8'h00;
    end else begin
      io_s1_r <= io_in;
      io_s2_r <= io_s1_r;
    end
  end

  // strobe low for the pulse width; a read also waits out the sync delay
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= S_IDLE;
      cnt_r   <= 3'h0;
      rd_r    <= 1'b0;
      done    <= 1'b0;
      rbyte_r <= 8'h00;
      cle     <= 1'b0;
      ale     <= 1'b0;
      we_n    <= 1'b1;
      re_n    <= 1'b1;
      io_out  <= 8'h00;
      io_oe   <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_r)
        S_IDLE: begin
          if (start) begin
            rd_r  <= (kind == 2'd3);
            cle   <= (kind == 2'd0);
            ale   <= (kind == 2'd1);
            if (kind == 2'd3) begin
              re_n  <= 1'b0;
              io_oe <= 1'b0;
              cnt_r <= RD_CYC[2:0];
            end else begin
              we_n   <= 1'b0;
              io_out <= wbyte;
              io_oe  <= 1'b1;
              cnt_r  <= WP_CYC[2:0];
            end
            state_r <= S_STRB;
          end
        end
        S_STRB: begin
          if (cnt_r > 3'h1) begin
            cnt_r <= cnt_r - 3'h1;
          end else begin
            // rising edge latches the byte; data and latches held one more cycle
            we_n <= 1'b1;
            re_n <= 1'b1;
            if (rd_r) begin
              rbyte_r <= io_s2_r;
            end
            state_r <= S_HOLD;
          end
        end
        S_HOLD: begin
          cle     <= 1'b0;
          ale     <= 1'b0;
          io_oe   <= 1'b0;
          done    <= 1'b1;
          state_r <= S_IDLE;
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end
endmodule

// ---- hw/nfc_host.v ----
// host controller for a 528-byte-page nand flash, driven by software over apb
// Functional notes
// - host encodes cycles by cle, ale, strobes
// - host keeps select low through busy; a deselect op raises it even while busy
// - address in four cycles, lsb first
// - fourth address cycle upper bits low
// - command set; only ff, 70, 71 while busy
// - at most three programs per page; counted for the last page programmed only, and any erase clears the count
`include "nfc_regs.vh"
module nfc_host (
  input  wire        pclk,            // clock, 10 mhz
  input  wire        presetn,         // async reset, active low
  input  wire        psel,            // apb select
  input  wire        penable,         // apb access phase
  input  wire        pwrite,          // apb direction
  input  wire [7:0]  paddr,           // apb byte address
  input  wire [31:0] pwdata,          // apb write data
  output wire [31:0] prdata,          // apb read data
  output wire        pready,          // apb ready
  output wire        pslverr,         // apb error on unmapped address
  output reg         chip_select_n,   // flash chip select
  output wire        command_latch_en,// flash command latch
  output wire        address_latch_en,// flash address latch
  output wire        write_strobe_n,  // flash write strobe
  output wire        read_strobe_n,   // flash read strobe
  output reg         write_protect_n, // flash write protect
  output wire [7:0]  io_out,          // flash port drive value
  output wire        io_oe,           // flash port drive enable
  input  wire [7:0]  io_in,           // flash port pins
  input  wire        ready_busy_n     // flash open-drain ready line
);
  localparam S_IDLE  = 3'd0;
  localparam S_FETCH = 3'd1;
  localparam S_ISSUE = 3'd2;
  localparam S_WAITE = 3'd3;
  localparam S_RDY   = 3'd4;
  localparam S_DES   = 3'd5;
  localparam integer CEH_CYC = `NFC_CEH_CYC;  // deselect_high_time in clocks

  reg  [2:0]  state_r;
  reg  [2:0]  op_r;
  reg  [7:0]  cmd_r;
  reg  [25:0] addr_r;
  reg  [9:0]  count_r;
  reg  [9:0]  bptr_r;
  reg  [9:0]  idx_r;
  reg  [1:0]  acyc_r;
  reg  [2:0]  dcnt_r;
  reg         refused_r;
  reg         done_r;
  reg         rd_wait_r;
  reg         rb_s1_r;
  reg         rb_s2_r;
  reg  [16:0] last_page_r;
  reg  [1:0]  prog_cnt_r;
  reg         cyc_start;
  reg  [1:0]  cyc_kind;
  reg  [7:0]  cyc_byte;
  wire        cyc_done;
  wire [7:0]  rbyte;
  wire [7:0]  buf_rdata;
  wire        busy;
  wire        wr_acc;
  wire        rd_acc;
  wire        sel_ok;
  wire        launch;
  wire        cmd_is_prog;
  wire        cmd_busy_ok;
  wire        cmd_refuse;
  wire        buf_we;
  wire [9:0]  buf_waddr;
  wire [7:0]  buf_wdata;
  wire [9:0]  buf_raddr;
  reg  [31:0] rdata_mux;

  // ready line is asynchronous to us: two flops before use
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rb_s1_r <= 1'b1;
      rb_s2_r <= 1'b1;
    end else begin
      rb_s1_r <= ready_busy_n;
      rb_s2_r <= rb_s1_r;
    end
  end

  assign busy   = (state_r != S_IDLE);
  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & penable & ~pwrite;
  assign sel_ok = (paddr[1:0] == 2'b00) && (paddr <= `NFC_OFF_STATUS);
  assign launch = wr_acc && (paddr == `NFC_OFF_CTRL) && !busy;

  // buffer reads need one wait state because memory data is registered
  assign pready  = ~(rd_acc && (paddr == `NFC_OFF_BUFDATA) && !rd_wait_r);
  assign pslverr = psel & penable & ~sel_ok;
  assign prdata  = rdata_mux;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_wait_r <= 1'b0;
    end else begin
      rd_wait_r <= rd_acc && (paddr == `NFC_OFF_BUFDATA) && !rd_wait_r;
    end
  end

  // command screening: busy allows only reset and status reads
  assign cmd_is_prog = (cmd_r == `NFC_CMD_PROG) || (cmd_r == `NFC_CMD_PROG_DUM) ||
                       (cmd_r == `NFC_CMD_PROG_MB);
  assign cmd_busy_ok = (cmd_r == `NFC_CMD_RESET) || (cmd_r == `NFC_CMD_STAT1) ||
                       (cmd_r == `NFC_CMD_STAT2);
  assign cmd_refuse  = (!rb_s2_r && !cmd_busy_ok) ||
                       (!write_protect_n && (cmd_is_prog ||
                        cmd_r == `NFC_CMD_ERASE2)) ||
                       (cmd_is_prog && last_page_r == addr_r[25:9] &&
                        prog_cnt_r == `NFC_MAX_PROGS);

  // apb read mux; reserved bits read zero
  always @* begin
    rdata_mux = 32'h0000_0000;
    case (paddr)
      `NFC_OFF_CTRL:    rdata_mux = {29'h0000_0000, op_r};
      `NFC_OFF_WPCTL:   rdata_mux = {31'h0000_0000, write_protect_n};
      `NFC_OFF_CMD:     rdata_mux = {24'h00_0000, cmd_r};
      `NFC_OFF_ADDR:    rdata_mux = {6'h00, addr_r};
      `NFC_OFF_COUNT:   rdata_mux = {22'h00_0000, count_r};
      `NFC_OFF_BUFPTR:  rdata_mux = {22'h00_0000, bptr_r};
      `NFC_OFF_BUFDATA: rdata_mux = {24'h00_0000, buf_rdata};
      `NFC_OFF_STATUS:  rdata_mux = {16'h0000, rbyte, 4'h0, done_r, refused_r,
                                     rb_s2_r, busy};
      default:          rdata_mux = 32'h0000_0000;
    endcase
  end

  // buffer ports: the sequencer owns them while an operation runs
  assign buf_we    = busy ? (op_r == `NFC_OP_RDATA && cyc_done)
                          : (wr_acc && paddr == `NFC_OFF_BUFDATA);
  assign buf_waddr = busy ? idx_r : bptr_r;
  assign buf_wdata = busy ? rbyte : pwdata[7:0];
  assign buf_raddr = busy ? idx_r : bptr_r;

  // software registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      write_protect_n <= `NFC_RST_WP_N;
      cmd_r           <= `NFC_RST_CMD;
      addr_r          <= 26'h000_0000;
      count_r         <= 10'h000;
      bptr_r          <= 10'h000;
    end else if (wr_acc && !busy) begin
      case (paddr)
        `NFC_OFF_WPCTL:   write_protect_n <= pwdata[0];
        `NFC_OFF_CMD:     cmd_r <= pwdata[7:0];
        `NFC_OFF_ADDR:    addr_r <= pwdata[25:0];
        `NFC_OFF_COUNT:   count_r <= pwdata[9:0];
        `NFC_OFF_BUFPTR:  bptr_r <= pwdata[9:0];
        `NFC_OFF_BUFDATA: bptr_r <= bptr_r + 10'h001;
        default:          bptr_r <= bptr_r;
      endcase
    end else if (rd_acc && pready && paddr == `NFC_OFF_BUFDATA) begin
      bptr_r <= bptr_r + 10'h001;
    end
  end

  // byte for the current cycle; bit 8 of the address is never sent
  always @* begin
    cyc_byte = cmd_r;
    cyc_kind = 2'd0;
    case (op_r)
      `NFC_OP_ADDR: begin
        cyc_kind = 2'd1;
        case (acyc_r)
          2'd0:    cyc_byte = addr_r[7:0];
          2'd1:    cyc_byte = addr_r[16:9];
          2'd2:    cyc_byte = addr_r[24:17];
          default: cyc_byte = {7'h00, addr_r[25]};
        endcase
      end
      `NFC_OP_WDATA: begin
        cyc_kind = 2'd2;
        cyc_byte = buf_rdata;
      end
      `NFC_OP_RDATA: cyc_kind = 2'd3;
      default:       cyc_kind = 2'd0;
    endcase
  end

  // sequencer; select stays low from an op until a deselect op, so a
  // read busy period is cut short by the host only on a deselect op, which busy does not hold off
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r       <= S_IDLE;
      op_r          <= 3'h0;
      idx_r         <= 10'h000;
      acyc_r        <= 2'd0;
      dcnt_r        <= 3'h0;
      cyc_start     <= 1'b0;
      chip_select_n <= 1'b1;
      refused_r     <= 1'b0;
      done_r        <= 1'b0;
      last_page_r   <= 17'h0_0000;
      prog_cnt_r    <= 2'd0;
    end else begin
      cyc_start <= 1'b0;
      // sticky flags: write one clears, a new event in the same cycle wins
      if (wr_acc && paddr == `NFC_OFF_STATUS) begin
        if (pwdata[`NFC_ST_REFUSED]) refused_r <= 1'b0;
        if (pwdata[`NFC_ST_DONE])    done_r <= 1'b0;
      end
      case (state_r)
        S_IDLE: begin
          if (launch) begin
            op_r   <= pwdata[2:0];
            idx_r  <= 10'h000;
            acyc_r <= 2'd0;
            case (pwdata[2:0])
              `NFC_OP_CMD: begin
                if (cmd_refuse) begin
                  refused_r <= 1'b1;
                  done_r    <= 1'b1;
                end else begin
                  chip_select_n <= 1'b0;
                  cyc_start     <= 1'b1;
                  state_r       <= S_WAITE;
                  if (cmd_r == `NFC_CMD_ERASE2) begin
                    prog_cnt_r <= 2'd0;
                  end else if (cmd_is_prog) begin
                    last_page_r <= addr_r[25:9];
                    prog_cnt_r  <= (last_page_r == addr_r[25:9]) ?
                                   prog_cnt_r + 2'd1 : 2'd1;
                  end
                end
              end
              `NFC_OP_ADDR, `NFC_OP_RDATA: begin
                chip_select_n <= 1'b0;
                state_r       <= S_ISSUE;
              end
              `NFC_OP_WDATA: begin
                chip_select_n <= 1'b0;
                state_r       <= S_FETCH;
              end
              `NFC_OP_WAITRDY: state_r <= S_RDY;
              `NFC_OP_DESEL: begin
                chip_select_n <= 1'b1;
                dcnt_r        <= CEH_CYC[2:0];
                state_r       <= S_DES;
              end
              default: done_r <= 1'b1;
            endcase
          end
        end
        S_FETCH: state_r <= S_ISSUE;                      // buffer read latency
        S_ISSUE: begin
          if ((op_r == `NFC_OP_WDATA || op_r == `NFC_OP_RDATA) &&
              idx_r >= count_r) begin
            done_r  <= 1'b1;
            state_r <= S_IDLE;
          end else begin
            cyc_start <= 1'b1;
            state_r   <= S_WAITE;
          end
        end
        S_WAITE: begin
          if (cyc_done) begin
            if (op_r == `NFC_OP_ADDR && acyc_r != 2'd3) begin
              acyc_r  <= acyc_r + 2'd1;
              state_r <= S_ISSUE;
            end else if (op_r == `NFC_OP_WDATA || op_r == `NFC_OP_RDATA) begin
              idx_r   <= idx_r + 10'h001;
              state_r <= (op_r == `NFC_OP_WDATA) ? S_FETCH : S_ISSUE;
            end else begin
              done_r  <= 1'b1;
              state_r <= S_IDLE;
            end
          end
        end
        S_RDY: begin
          // select left as it is, so a read transfer is not cut short
          if (rb_s2_r) begin
            done_r  <= 1'b1;
            state_r <= S_IDLE;
          end
        end
        S_DES: begin
          if (dcnt_r > 3'h1) begin
            dcnt_r <= dcnt_r - 3'h1;
          end else begin
            done_r  <= 1'b1;
            state_r <= S_IDLE;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  nfc_cycle u_cycle (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (cyc_start),
    .kind    (cyc_kind),
    .wbyte   (cyc_byte),
    .done    (cyc_done),
    .rbyte_r (rbyte),
    .cle     (command_latch_en),
    .ale     (address_latch_en),
    .we_n    (write_strobe_n),
    .re_n    (read_strobe_n),
    .io_out  (io_out),
    .io_oe   (io_oe),
    .io_in   (io_in)
  );

  nfc_buf_mem u_buf (
    .pclk  (pclk),
    .we    (buf_we),
    .waddr (buf_waddr),
    .wdata (buf_wdata),
    .raddr (buf_raddr),
    .rdata (buf_rdata)
  );
endmodule

// ---- testbench/nfc_flash_model.sv ----
// behavioural nand flash device answering the host controller pins
module nfc_flash_model #(
  parameter int BUSY_NS = 5000  // program and erase busy span, shortened
) (
  input  logic       chip_select_n,    // select, active low
  input  logic       command_latch_en, // command latch
  input  logic       address_latch_en, // address latch
  input  logic       write_strobe_n,   // write strobe
  input  logic       read_strobe_n,    // read strobe
  input  logic       write_protect_n,  // write protect
  input  logic [7:0] io_in,            // port as driven by the host
  output logic [7:0] io_dev,           // device drive value
  output logic       io_dev_oe,        // device drives the port
  output logic       rb_pull_low       // open-drain busy pull
);
  logic [7:0] mem [0:527];  // one page register
  logic [7:0] ab  [0:3];
  logic [7:0] cmd_r = 8'h00;
  logic [7:0] q = 8'h00;
  logic       half_page_select = 1'b0;
  logic       rd_mode = 1'b0;
  logic       busy = 1'b0;
  logic       standby = 1'b1;
  int         ac = 0;
  int         col = 0;
  int         nbusy = 0;
  event       go;
  assign rb_pull_low = busy;
  // drive only while selected and read strobe low
  assign io_dev_oe = !chip_select_n && !read_strobe_n;
  assign io_dev    = io_dev_oe ? q : ~q;  // released port must not show stale data
  // everything latches on the write strobe rising edge
  always @(posedge write_strobe_n) begin
    if (command_latch_en && (!busy || io_in inside {8'hff, 8'h70, 8'h71})) begin
      cmd_r = io_in;
      ac = 0;
      if (io_in inside {8'h00, 8'h01, 8'h50}) rd_mode = 1'b1;
      if (io_in inside {8'h00, 8'h01}) half_page_select = io_in[0];
      if (io_in inside {8'h10, 8'h11, 8'h15, 8'hd0} && write_protect_n) begin
        nbusy++;
        ->go;
      end
    end else if (address_latch_en) begin
      if (ac < 4) ab[ac] = io_in;
      ac++;
      col = ab[0];
    end else if (!command_latch_en) begin
      mem[col % 528] = io_in;
      col++;
    end
  end
  // busy span after a program or erase start
  always @(go) begin
    busy = 1'b1;
    #(BUSY_NS);
    busy = 1'b0;
  end
  // read strobe fall presents the byte and moves the column
  always @(negedge read_strobe_n) if (!chip_select_n) begin
    q = mem[col % 528];
    col++;
  end
  // deselect ends a read unless busy
  always @(posedge chip_select_n) if (!busy) standby = 1'b1;
  always @(negedge chip_select_n) standby = 1'b0;
endmodule

// ---- testbench/nfc_host_props.sv ----
// concurrent checks on the pins and apb side of the flash host controller
module nfc_host_props (
  input wire logic       pclk,             // clock
  input wire logic       presetn,          // reset, active low
  input wire logic       psel,             // apb select
  input wire logic       penable,          // apb access
  input wire logic [7:0] paddr,            // apb address
  input wire logic       pslverr,          // apb error
  input wire logic       chip_select_n,    // flash select
  input wire logic       command_latch_en, // command latch
  input wire logic       address_latch_en, // address latch
  input wire logic       write_strobe_n,   // write strobe
  input wire logic       read_strobe_n,    // read strobe
  input wire logic       write_protect_n,  // write protect
  input wire logic [7:0] io_out,           // port drive value
  input wire logic       io_oe             // port drive enable
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [2:0] acnt_r;
  // address cycles since the last command, to find the fourth one
  always @(posedge pclk or negedge presetn)
    if (!presetn) acnt_r <= 3'h0;
    else if (command_latch_en && !write_strobe_n) acnt_r <= 3'h0;
    else if (address_latch_en && !write_strobe_n) acnt_r <= acnt_r + 3'h1;
  sequence s_wr;
    !write_strobe_n ##1 write_strobe_n ##1 !command_latch_en && !address_latch_en && !io_oe;
  endsequence
  sequence s_rd;
    !read_strobe_n [*3] ##1 read_strobe_n;
  endsequence
  a_write_cycle: assert property ($fell(write_strobe_n) |-> s_wr)
    else $error("write cycle shape wrong");
  a_read_pulse: assert property ($fell(read_strobe_n) |-> s_rd)
    else $error("read strobe width wrong");
  a_latch_excl: assert property (!(command_latch_en && address_latch_en))
    else $error("both latches high");
  a_strobe_select: assert property ((!write_strobe_n || !read_strobe_n) |-> !chip_select_n)
    else $error("strobe without select");
  a_write_drive: assert property (!write_strobe_n |-> io_oe && read_strobe_n)
    else $error("port not driven in write");
  a_read_float: assert property (!read_strobe_n |-> !io_oe && !command_latch_en)
    else $error("host drives port during read");
  a_wp_inhibit: assert property ((command_latch_en && !write_strobe_n && !write_protect_n)
    |-> !(io_out inside {8'h10, 8'h11, 8'h15, 8'hd0}))
    else $error("program or erase sent while protected");
  a_fourth_addr: assert property ((address_latch_en && !write_strobe_n && acnt_r == 3'h3)
    |-> io_out[7:1] == 7'h00)
    else $error("fourth address byte upper bits set");
  a_unmapped_err: assert property ((psel && penable && paddr > 8'h1c) |-> pslverr)
    else $error("unmapped access without error");
endmodule
bind nfc_host nfc_host_props i_nfc_host_props (.pclk, .presetn, .psel, .penable, .paddr,
  .pslverr, .chip_select_n, .command_latch_en, .address_latch_en, .write_strobe_n,
  .read_strobe_n, .write_protect_n, .io_out, .io_oe);

// ---- testbench/nfc_host_tb_top.sv ----
// self-checking bench: apb master, flash model and directed plus random tests
`include "nfc_regs.vh"
module nfc_host_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, perr;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd;
  logic [25:0] a;
  logic [7:0]  d [0:7];
  logic [7:0]  cl [0:9] = '{8'h80, 8'h00, 8'h01, 8'h50, 8'hff, 8'h70, 8'h71, 8'h90, 8'h91, 8'h60};
  wire [31:0] prdata;
  wire [7:0]  io_out, io_dev, io_in;
  wire        pready, pslverr, chip_select_n, command_latch_en, address_latch_en;
  wire        write_strobe_n, read_strobe_n, write_protect_n, io_oe, io_dev_oe, rb_pull_low;
  wire        ready_busy_n;
  int         err_count = 0, comparisons = 0;
  always #50 pclk = ~pclk;
  // shared port and pulled-up busy line
  assign io_in = io_oe ? io_out : io_dev;
  assign ready_busy_n = !rb_pull_low;
  nfc_host i_nfc_host (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .chip_select_n, .command_latch_en, .address_latch_en, .write_strobe_n,
    .read_strobe_n, .write_protect_n, .io_out, .io_oe, .io_in, .ready_busy_n);
  nfc_flash_model i_nfc_flash_model (.chip_select_n, .command_latch_en, .address_latch_en,
    .write_strobe_n, .read_strobe_n, .write_protect_n, .io_in, .io_dev, .io_dev_oe,
    .rb_pull_low);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer, entered just after a rising edge; one idle edge after it
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (!pready) @(posedge pclk);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // launch an op, wait for done, compare the refused flag, clear both flags
  task automatic op(input logic [2:0] o, input logic refd);
    int n;
    n = 0;
    apb(1'b1, `NFC_OFF_CTRL, {29'h0, o});
    do begin
      apb(1'b0, `NFC_OFF_STATUS, 32'h0);
      n++;
    end while (rd[`NFC_ST_DONE] !== 1'b1 && n < 500);
    chk(rd[`NFC_ST_DONE], 1'b1);
    chk(rd[`NFC_ST_REFUSED], refd);
    apb(1'b1, `NFC_OFF_STATUS, 32'hc);
  endtask
  task automatic cmd(input logic [7:0] c, input logic refd);
    apb(1'b1, `NFC_OFF_CMD, {24'h0, c});
    op(`NFC_OP_CMD, refd);
  endtask
  // address byte k as the four address cycles carry it
  function automatic logic [7:0] ab_exp(input logic [25:0] x, input int k);
    case (k)
      0: return x[7:0];
      1: return x[16:9];
      2: return x[24:17];
      default: return {7'h0, x[25]};
    endcase
  endfunction
  task automatic finish_test;
    $display("counts: comparisons=%0d mismatches=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // watchdog, well beyond the expected run of about a thousand cycles
  initial begin
    #4000000;
    err_count++;
    finish_test();
  end
  // main sequence
  initial begin
    void'($urandom(32'h030d));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `NFC_OFF_WPCTL, 32'h0);
    chk(rd, {31'h0, `NFC_RST_WP_N});
    apb(1'b0, 8'h40, 32'h0);
    chk(perr, 1'b1);
    $display("test reset and map done");
    foreach (cl[i]) begin
      cmd(cl[i], 1'b0);
      chk(i_nfc_flash_model.cmd_r, cl[i]);
    end
    cmd(8'h10, 1'b1);
    chk(i_nfc_flash_model.cmd_r, 8'h60);
    $display("test commands done");
    apb(1'b1, `NFC_OFF_WPCTL, 32'h1);
    cmd(8'hd0, 1'b0);
    cmd(8'h00, 1'b1);
    cmd(8'h70, 1'b0);
    op(`NFC_OP_DESEL, 1'b0);
    chk(i_nfc_flash_model.standby, 1'b0);
    op(`NFC_OP_WAITRDY, 1'b0);
    chk(ready_busy_n, 1'b1);
    chk(i_nfc_flash_model.nbusy, 1);
    $display("test busy done");
    a = 26'($urandom);
    cmd(8'h00, 1'b0);
    apb(1'b1, `NFC_OFF_ADDR, {6'h0, a});
    op(`NFC_OP_ADDR, 1'b0);
    for (int k = 0; k < 4; k++) chk(i_nfc_flash_model.ab[k], ab_exp(a, k));
    chk(i_nfc_flash_model.col, a[7:0]);
    apb(1'b1, `NFC_OFF_BUFPTR, 32'h0);
    for (int k = 0; k < 8; k++) begin
      d[k] = 8'($urandom);
      apb(1'b1, `NFC_OFF_BUFDATA, {24'h0, d[k]});
    end
    apb(1'b1, `NFC_OFF_COUNT, 32'h8);
    op(`NFC_OP_WDATA, 1'b0);
    for (int k = 0; k < 8; k++) chk(i_nfc_flash_model.mem[a[7:0] + k], d[k]);
    $display("test address and write done");
    op(`NFC_OP_ADDR, 1'b0);
    apb(1'b1, `NFC_OFF_BUFPTR, 32'h0);
    for (int k = 0; k < 8; k++) apb(1'b1, `NFC_OFF_BUFDATA, 32'h0);
    op(`NFC_OP_RDATA, 1'b0);
    chk(i_nfc_flash_model.col, a[7:0] + 8);
    apb(1'b1, `NFC_OFF_BUFPTR, 32'h0);
    for (int k = 0; k < 8; k++) begin
      apb(1'b0, `NFC_OFF_BUFDATA, 32'h0);
      chk(rd[7:0], d[k]);
    end
    op(`NFC_OP_DESEL, 1'b0);
    chk(i_nfc_flash_model.standby, 1'b1);
    $display("test read done");
    for (int i = 0; i < 4; i++) begin
      cmd(8'h80, 1'b0);
      op(`NFC_OP_ADDR, 1'b0);
      cmd(8'h10, i == 3);
      op(`NFC_OP_WAITRDY, 1'b0);
    end
    chk(i_nfc_flash_model.nbusy, 4);
    $display("test program limit done");
    finish_test();
  end
endmodule
